// File: tcw_pkg.sv
// Package for the 8-bit compare timer: register map, fields, modes and actions
package tcw_pkg;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_COUNT = 4'h4;
	localparam logic [3:0] REG_CMP = 4'h8;
	localparam logic [3:0] REG_FLAGS = 4'hc;
	localparam logic [3:0] REG_PORT = 4'h0 + 4'h0;
	localparam int CTRL_FORCE_BIT = 7;
	localparam int CTRL_WAVE_LSB = 3;
	localparam int CTRL_ACT_LSB = 5;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_DIR_BIT = 1;
	localparam int CTRL_PORT_BIT = 2;
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		WAVE_NORMAL = 2'h0,
		WAVE_PHASE = 2'h1,
		WAVE_CLEAR_ON_MATCH = 2'h2,
		WAVE_FAST = 2'h3
	} tcw_wave_t;
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_CLEAR = 2'h2,
		ACT_SET = 2'h3
	} tcw_act_t;
endpackage

// File: tcw_timer.sv
// 8-bit timer with one compare channel, waveform output and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Function
// - Count write blocks compare matches during the next timer clock cycle.
// - Compare output state keeps its value across waveform mode changes.
// - Output action setting is unbuffered, acts from the next match.
// - Nonzero output action routes compare output to pin; direction bit controls enable.
// - Pin override behaves the same in every waveform mode.
// - Output action zero leaves compare output unchanged on matches.
// - Force strobe applies the output action immediately in non-PWM modes.
// - Counting depends only on waveform mode, never on output action.
// - Normal mode always increments and wraps from 0xff to 0x00.
// - Normal mode sets overflow flag when count becomes zero; counting never clears it.
// - Clear-on-match mode clears counter when count equals compare value.
// - Compare writes unbuffered there; a lower value makes the counter wrap first.
// - Clear-on-match with action one toggles output on every match.
// - Clear-on-match raises compare flag each time the top is reached.
// - Clear-on-match sets overflow flag when count passes max to zero.
// - Fast PWM counts zero to max then restarts from zero.
// - Fast PWM action 2 clears on match, sets at bottom; 3 reverses.
// - Fast PWM clears the counter the cycle after it equals max.
// - Fast PWM sets overflow flag each time the counter reaches max.
// - Fast PWM compare zero spikes; compare max gives constant level.
// - Fast PWM with action one toggles on match, compare still buffered.
// - PWM modes buffer compare writes, loaded at bottom in fast PWM only, never in phase mode; others write directly.
// - Match sets compare flag on the same timer cycle that sees it; writing one clears it.
// - Count write has priority over any clear or count operation.
// - Forced compare sets no flag and does not touch the counter.
module tcw_timer (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire logic [31:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [31:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_overflow_flag,
	output logic o_compare_match_flag
);
	import tcw_pkg::*;

	typedef struct packed {
		logic [7:0] timer_count;
		logic [7:0] compare_value;
		logic [7:0] compare_buffer;
		logic compare_output;
		logic overflow_flag;
		logic compare_match_flag;
		tcw_wave_t waveform_mode_select;
		tcw_act_t output_action_select;
		logic timer_run;
		logic compare_pin_direction_bit;
		logic port_value;
		logic block_match;
		logic match_pending;
		logic aw_held;
		logic [3:0] aw_addr;
		logic aw_bad;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic pin_out;
		logic pin_oe;
	} tcw_state_t;

	tcw_state_t st_ff;
	tcw_state_t nxt_st;

	logic tick;
	logic do_write;
	logic wr_ctrl;
	logic wr_count;
	logic wr_cmp;
	logic wr_flags;
	logic force_now;
	logic is_pwm;
	logic match;
	logic [7:0] rd_word;
	logic rd_bad;

	always_comb begin
		nxt_st = st_ff;
		tick = i_tick & st_ff.timer_run;
		is_pwm = st_ff.waveform_mode_select[0];
		// Register bus write: both halves may arrive in any order
		if (i_awvalid && !st_ff.aw_held) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = i_awaddr[3:0];
			nxt_st.aw_bad = (i_awaddr[31:4] != 28'h0000000) || (i_awaddr[1:0] != 2'h0);
		end
		if (i_wvalid && !st_ff.w_held) begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = i_wdata;
			nxt_st.w_strb = i_wstrb;
		end
		do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
		wr_ctrl = do_write && !st_ff.aw_bad && st_ff.aw_addr == REG_CTRL && st_ff.w_strb[0];
		wr_count = do_write && !st_ff.aw_bad && st_ff.aw_addr == REG_COUNT && st_ff.w_strb[0];
		wr_cmp = do_write && !st_ff.aw_bad && st_ff.aw_addr == REG_CMP && st_ff.w_strb[0];
		wr_flags = do_write && !st_ff.aw_bad && st_ff.aw_addr == REG_FLAGS && st_ff.w_strb[0];
		if (do_write) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = (st_ff.aw_bad || st_ff.aw_addr > REG_FLAGS) ? RESP_SLVERR : RESP_OKAY;
		end
		if (st_ff.bvalid && i_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Control word: run, direction, port value, mode, action; force is a strobe
		force_now = wr_ctrl && st_ff.w_data[CTRL_FORCE_BIT] && !st_ff.w_data[CTRL_WAVE_LSB];
		if (wr_ctrl) begin
			nxt_st.timer_run = st_ff.w_data[CTRL_RUN_BIT];
			nxt_st.compare_pin_direction_bit = st_ff.w_data[CTRL_DIR_BIT];
			nxt_st.port_value = st_ff.w_data[CTRL_PORT_BIT];
			nxt_st.waveform_mode_select = tcw_wave_t'(st_ff.w_data[CTRL_WAVE_LSB +: 2]);
			nxt_st.output_action_select = tcw_act_t'(st_ff.w_data[CTRL_ACT_LSB +: 2]);
		end
		// Compare value: buffered in PWM modes, direct otherwise
		if (wr_cmp) begin
			nxt_st.compare_buffer = st_ff.w_data[7:0];
			if (!is_pwm) begin
				nxt_st.compare_value = st_ff.w_data[7:0];
			end
		end
		match = (st_ff.timer_count == st_ff.compare_value) && !st_ff.block_match;
		// Counter sequencing per timer clock
		if (tick) begin
			nxt_st.block_match = 1'b0;
			nxt_st.match_pending = match;
			case (st_ff.waveform_mode_select)
				WAVE_NORMAL: begin
					nxt_st.timer_count = st_ff.timer_count + CNT_ONE;
					if (st_ff.timer_count == CNT_MAX) begin
						nxt_st.overflow_flag = 1'b1;
					end
				end
				WAVE_CLEAR_ON_MATCH: begin
					if (match) begin
						nxt_st.timer_count = CNT_BOTTOM;
					end else begin
						nxt_st.timer_count = st_ff.timer_count + CNT_ONE;
					end
					if (st_ff.timer_count == CNT_MAX) begin
						nxt_st.overflow_flag = 1'b1;
					end
				end
				WAVE_FAST: begin
					if (st_ff.timer_count == CNT_MAX) begin
						nxt_st.timer_count = CNT_BOTTOM;
						nxt_st.compare_value = st_ff.compare_buffer;
						if (st_ff.output_action_select == ACT_CLEAR) begin
							nxt_st.compare_output = 1'b1;
						end else if (st_ff.output_action_select == ACT_SET) begin
							nxt_st.compare_output = 1'b0;
						end
					end else begin
						nxt_st.timer_count = st_ff.timer_count + CNT_ONE;
					end
					if (st_ff.timer_count + CNT_ONE == CNT_MAX) begin
						nxt_st.overflow_flag = 1'b1;
					end
				end
				default: begin
					nxt_st.timer_count = st_ff.timer_count + CNT_ONE;
				end
			endcase
			// Match action applied with the counter step; at max it overrides bottom
			if (match) begin
				case (st_ff.output_action_select)
					ACT_TOGGLE: nxt_st.compare_output = ~st_ff.compare_output;
					ACT_CLEAR: nxt_st.compare_output = 1'b0;
					ACT_SET: nxt_st.compare_output = 1'b1;
					default: nxt_st.compare_output = st_ff.compare_output;
				endcase
			end
		end
		if (st_ff.match_pending && tick) begin
			nxt_st.match_pending = match;
		end
		// Flag raised on the same timer clock that sees the match
		if (tick && match) begin
			nxt_st.compare_match_flag = 1'b1;
		end
		if (force_now) begin
			case (tcw_act_t'(st_ff.w_data[CTRL_ACT_LSB +: 2]))
				ACT_TOGGLE: nxt_st.compare_output = ~st_ff.compare_output;
				ACT_CLEAR: nxt_st.compare_output = 1'b0;
				ACT_SET: nxt_st.compare_output = 1'b1;
				default: nxt_st.compare_output = st_ff.compare_output;
			endcase
		end
		// Software write to the count wins over counting and clearing
		if (wr_count) begin
			nxt_st.timer_count = st_ff.w_data[7:0];
			nxt_st.block_match = 1'b1;
		end
		// Write-one-to-clear; a simultaneous set wins, for overflow only if that flag was clear
		if (wr_flags) begin
			if (st_ff.w_data[FLAG_OVF_BIT] && !(nxt_st.overflow_flag && !st_ff.overflow_flag)) begin
				nxt_st.overflow_flag = 1'b0;
			end
			if (st_ff.w_data[FLAG_CMP_BIT] && !(tick && match)) begin
				nxt_st.compare_match_flag = 1'b0;
			end
		end
		// Register bus read
		rd_bad = (i_araddr[31:4] != 28'h0000000) || (i_araddr[1:0] != 2'h0);
		case (i_araddr[3:0])
			REG_CTRL: rd_word = {1'b0, st_ff.output_action_select, st_ff.waveform_mode_select,
				st_ff.port_value, st_ff.compare_pin_direction_bit, st_ff.timer_run};
			REG_COUNT: rd_word = st_ff.timer_count;
			REG_CMP: rd_word = is_pwm ? st_ff.compare_buffer : st_ff.compare_value;
			REG_FLAGS: rd_word = {6'h00, st_ff.compare_match_flag, st_ff.overflow_flag};
			default: begin
				rd_word = 8'h00;
				rd_bad = 1'b1;
			end
		endcase
		if (i_arvalid && !st_ff.rvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_bad ? 32'h00000000 : {24'h000000, rd_word};
			nxt_st.rresp = rd_bad ? RESP_SLVERR : RESP_OKAY;
		end
		if (st_ff.rvalid && i_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		// Pin override independent of waveform mode
		nxt_st.pin_out = (nxt_st.output_action_select != ACT_NONE) ?
			nxt_st.compare_output : nxt_st.port_value;
		nxt_st.pin_oe = nxt_st.compare_pin_direction_bit;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_awready = !st_ff.aw_held;
	assign o_wready = !st_ff.w_held;
	assign o_bvalid = st_ff.bvalid;
	assign o_bresp = st_ff.bresp;
	assign o_arready = !st_ff.rvalid;
	assign o_rvalid = st_ff.rvalid;
	assign o_rdata = st_ff.rdata;
	assign o_rresp = st_ff.rresp;
	assign o_pin_out = st_ff.pin_out;
	assign o_pin_oe = st_ff.pin_oe;
	assign o_overflow_flag = st_ff.overflow_flag;
	assign o_compare_match_flag = st_ff.compare_match_flag;
endmodule
`default_nettype wire

// File: tcw_pin_model.sv
// Shared port pin with a pull-up, driven by the timer when enabled
`timescale 1ns/1ps
`default_nettype none
module tcw_pin_model (
	input wire logic i_out,
	input wire logic i_oe,
	output logic o_level
);
	assign o_level = i_oe ? i_out : 1'b1;
endmodule
`default_nettype wire

// File: tcw_timer_props.sv
// Port assertions for the compare timer
`timescale 1ns/1ps
`default_nettype none
module tcw_timer_props (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic o_pin_out,
	input wire logic o_pin_oe,
	input wire logic o_overflow_flag,
	input wire logic o_compare_match_flag
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_cpu_write;
		o_bvalid || $past(o_bvalid);
	endsequence
	a_bvalid_held: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("bvalid dropped");
	a_resp_after_aw: assert property ($rose(o_bvalid) |-> !$past(o_awready)) else $error("early bvalid");
	a_ovf_sticky: assert property (o_overflow_flag && o_awready && !i_awvalid |=> o_overflow_flag)
		else $error("overflow flag lost");
	a_cmp_sticky: assert property (o_compare_match_flag && o_awready && !i_awvalid
		|=> o_compare_match_flag) else $error("compare flag lost");
	a_ovf_tick: assert property ($rose(o_overflow_flag) |-> $past(i_tick)) else $error("ovf");
	a_cmp_tick: assert property ($rose(o_compare_match_flag) |-> $past(i_tick))
		else $error("compare flag without tick");
	a_pin_cause: assert property ($changed(o_pin_out) |-> $past(i_tick) || o_bvalid
		|| $past(o_bvalid)) else $error("pin moved without cause");
	a_oe_by_write: assert property ($changed(o_pin_oe) |-> s_cpu_write) else $error("oe moved");
endmodule
bind tcw_timer tcw_timer_props i_tcw_timer_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_tick(i_tick), .i_awvalid(i_awvalid), .o_awready(o_awready), .o_bvalid(o_bvalid),
	.i_bready(i_bready), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
	.o_overflow_flag(o_overflow_flag), .o_compare_match_flag(o_compare_match_flag));
`default_nettype wire

// File: test_timer8_compare_waveform.sv
// Self-checking bench for the compare timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_timer8_compare_waveform;
	import tcw_pkg::*;
	logic clk = 0, rst = 1, tick = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wrd, bv, arr, rv, pin, oe, ovf, cmf, lvl;
	logic [1:0] br, rr;
	logic [31:0] awa = 0, wd = 0, ara = 0, rdat;
	int failures = 0, samples_checked = 0;
	tcw_timer i_tcw_timer (.i_clk(clk), .i_sys_rst(rst), .i_tick(tick), .i_awaddr(awa),
		.i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'h1), .i_wvalid(wv),
		.o_wready(wrd), .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara),
		.i_arvalid(arv), .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv),
		.i_rready(rry), .o_pin_out(pin), .o_pin_oe(oe), .o_overflow_flag(ovf),
		.o_compare_match_flag(cmf));
	tcw_pin_model i_tcw_pin_model (.i_out(pin), .i_oe(oe), .o_level(lvl));
	initial forever #2.5 clk = ~clk;
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		final_report();
	end
	task automatic final_report;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] a, input logic f);
		return {f, a, m, 3'b011};
	endfunction
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		logic ra, rw, rb;
		@(posedge clk);
		awa <= {24'h0, a};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(negedge clk);
			ra = awv & awr;
			rw = wv & wrd;
			rb = (bv === 1'b1);
			@(posedge clk);
			if (ra) awv <= 1'b0;
			if (rw) wv <= 1'b0;
		end while (!rb);
		bry <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
		input string n);
		logic ra, rb;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		ara <= {24'h0, a};
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(negedge clk);
			ra = arv & arr;
			rb = (rv === 1'b1);
			d = rdat;
			r = rr;
			@(posedge clk);
			if (ra) arv <= 1'b0;
		end while (!rb);
		rry <= 1'b0;
		`CHK(n, e, d)
		`CHK("rresp", er, r)
	endtask
	task automatic ticks(input int n);
		@(posedge clk);
		tick <= 1'b1;
		repeat (n) @(posedge clk);
		tick <= 1'b0;
		#1;
	endtask
	task automatic t_normal;
		bus_rd(REG_FLAGS, 32'h0, RESP_OKAY, "flags");
		bus_rd(8'h10, 32'h0, RESP_SLVERR, "unmapped");
		bus_wr(REG_COUNT, 8'hfe);
		bus_wr(REG_CTRL, ctl(WAVE_NORMAL, ACT_NONE, 1'b0));
		ticks(4);
		`CHK("ovf", 1'b1, ovf)
		bus_rd(REG_COUNT, 32'h2, RESP_OKAY, "wrap");
	endtask
	task automatic t_ctc;
		bus_wr(REG_CMP, 8'h03);
		bus_wr(REG_COUNT, 8'h00);
		bus_wr(REG_CTRL, ctl(WAVE_CLEAR_ON_MATCH, ACT_TOGGLE, 1'b0));
		bus_wr(REG_FLAGS, 8'h03);
		ticks(4);
		`CHK("cmp flag", 1'b1, cmf)
		`CHK("toggle", 1'b1, lvl)
		bus_wr(REG_FLAGS, 8'h03);
		bus_wr(REG_COUNT, 8'h03);
		ticks(253);
		`CHK("wrap ovf", 1'b1, ovf)
		`CHK("blocked", 1'b0, cmf)
		bus_rd(REG_COUNT, 32'h0, RESP_OKAY, "late top");
	endtask
	task automatic t_pwm;
		bus_wr(REG_CTRL, ctl(WAVE_NORMAL, ACT_CLEAR, 1'b1));
		`CHK("force", 1'b0, lvl)
		bus_wr(REG_CTRL, ctl(WAVE_NORMAL, ACT_TOGGLE, 1'b1));
		bus_wr(REG_CTRL, ctl(WAVE_FAST, ACT_SET, 1'b0));
		`CHK("mode keep", 1'b1, lvl)
		bus_wr(REG_COUNT, 8'hfe);
		bus_wr(REG_CMP, 8'h10);
		ticks(2);
		`CHK("bottom", 1'b0, lvl)
		ticks(17);
		`CHK("match", 1'b1, lvl)
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_normal();
		t_ctc();
		t_pwm();
		final_report();
	end
endmodule
`default_nettype wire
